// file: logic/sapc_core.sv
// Purpose: Pin-level control of an eight channel simultaneous sampling converter.
// Assumes: Conversion results arrive from the analog core on conv_data.
// Notes: Serial clock and read strobe are sampled pins, not clocks.
`timescale 1ns/1ps
module sapc_core
	import sapc_pkg::*;
#(
	parameter int CONV_CYC = sapc_pkg::SAPC_CONV_CYC
) (
	// Clock and resets.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reset_pin,
	// Mode pins.
	input wire logic ref_source_select,
	input wire logic range_select,
	input wire logic power_down_n,
	input wire logic interface_select,
	input wire logic msb_or_byte_select,
	// Conversion start pins.
	input wire logic sample_start_a,
	input wire logic sample_start_b,
	// Read pins.
	input wire logic cs_n,
	input wire logic rd_sclk,
	// Analog core results, eight words of sapc_pkg::SAPC_RES_BITS.
	input wire logic [8*sapc_pkg::SAPC_RES_BITS-1:0] conv_data,
	// Analog control outputs.
	output logic ref_internal_en,
	output logic ref_voltage_pin_oe,
	output logic ref_buffer_en,
	output logic span_wide,
	output logic [1:0] power_state,
	output logic hold_a,
	output logic hold_b,
	output logic busy,
	// Parallel bus.
	output logic [15:0] par_data,
	output logic par_oe,
	// Serial outputs.
	output logic serial_out_a,
	output logic serial_out_b,
	output logic serial_oe
);
	import sapc_pkg::*;

	sapc_mode_if mode_bus();
	logic [6:0] sync_out;
	logic rst_all_n;
	logic [1:0] rst_s_r;
	sapc_state_t state_r;
	logic [15:0] cnt_r;
	logic sa_q_r;
	logic sb_q_r;
	logic armed_a_r;
	logic armed_b_r;
	logic [15:0] data_r [SAPC_CHANNELS];
	logic [2:0] ch_r;
	logic [4:0] bit_r;
	logic byte_hi_r;
	logic rd_q_r;
	logic cs_q_r;
	logic rd_fall;
	logic rd_rise;
	logic cs_fall;

	// ---------------------------------------------------------------
	// Reset combine
	// ---------------------------------------------------------------
	// The reset pin clears conversion and readout state asynchronously; mode, power and strobe registers reset on rst_n only; release is synchronised.
	always_ff @(posedge clk or negedge rst_n or posedge reset_pin) begin
		if (!rst_n || reset_pin) begin
			rst_s_r <= 2'b00;
		end else begin
			rst_s_r <= {rst_s_r[0], 1'b1};
		end
	end
	assign rst_all_n = rst_s_r[1];

	// ---------------------------------------------------------------
	// Input synchronisers
	// ---------------------------------------------------------------
	// mode pin synchronisers.
	sapc_sync #(.N(7)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in({sample_start_b, sample_start_a, msb_or_byte_select, interface_select,
			ref_source_select, power_down_n, range_select}),
		.pin_out(sync_out)
	);
	assign mode_bus.span_wide = sync_out[0];
	assign mode_bus.power_down_n = sync_out[1];
	assign mode_bus.ref_internal = sync_out[2];
	assign mode_bus.ifsel = !sync_out[3] ? SAPC_IF_PAR : (sync_out[4] ? SAPC_IF_BYTE : SAPC_IF_SER);
	assign mode_bus.start_a = sync_out[5];
	assign mode_bus.start_b = sync_out[6];

	// ---------------------------------------------------------------
	// Reference, span and power
	// ---------------------------------------------------------------
	// Reference pin output follows its select pin, and the internal enable does too outside the off power state; the buffer is disabled only in the off power state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_internal_en <= 1'b0;
			ref_voltage_pin_oe <= 1'b0;
			ref_buffer_en <= 1'b0;
			span_wide <= 1'b0;
			power_state <= SAPC_PWR_RUN;
		end else begin
			ref_internal_en <= mode_bus.ref_internal && power_state != SAPC_PWR_OFF;
			ref_voltage_pin_oe <= mode_bus.ref_internal;
			ref_buffer_en <= power_state != SAPC_PWR_OFF;
			span_wide <= mode_bus.span_wide;
			if (mode_bus.power_down_n) begin
				power_state <= SAPC_PWR_RUN;
			end else if (mode_bus.span_wide) begin
				power_state <= SAPC_PWR_POWER_DOWN_N;
			end else begin
				power_state <= SAPC_PWR_OFF;
			end
		end
	end

	// ---------------------------------------------------------------
	// Conversion control
	// ---------------------------------------------------------------
	// edge capture per group, ignored while busy.
	always_ff @(posedge clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			// Edge memory starts high so a start level still standing after reset is not a rise.
			sa_q_r <= 1'b1;
			sb_q_r <= 1'b1;
			armed_a_r <= 1'b0;
			armed_b_r <= 1'b0;
		end else begin
			sa_q_r <= mode_bus.start_a;
			sb_q_r <= mode_bus.start_b;
			if (state_r == SAPC_ST_CONV) begin
				armed_a_r <= 1'b0;
				armed_b_r <= 1'b0;
			end else begin
				if (mode_bus.start_a && !sa_q_r) begin
					armed_a_r <= 1'b1;
				end
				if (mode_bus.start_b && !sb_q_r) begin
					armed_b_r <= 1'b1;
				end
			end
		end
	end

	// reset aborts conversion; state held while reset stands.
	always_ff @(posedge clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			state_r <= SAPC_ST_IDLE;
			cnt_r <= 16'h0000;
			busy <= 1'b0;
		end else begin
			case (state_r)
				SAPC_ST_IDLE: begin
					if (armed_a_r && armed_b_r && power_state == SAPC_PWR_RUN) begin
						state_r <= SAPC_ST_CONV;
						cnt_r <= 16'h0000;
						busy <= 1'b1;
					end
				end
				SAPC_ST_CONV: begin
					if (cnt_r == 16'(CONV_CYC - 1)) begin
						state_r <= SAPC_ST_DONE;
						busy <= 1'b0;
					end else begin
						cnt_r <= cnt_r + 16'h0001;
					end
				end
				SAPC_ST_DONE: begin
					state_r <= SAPC_ST_IDLE;
				end
				default: begin
					state_r <= SAPC_ST_IDLE;
				end
			endcase
		end
	end

	// Track-and-hold controls per channel group.
	always_ff @(posedge clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			hold_a <= 1'b0;
			hold_b <= 1'b0;
		end else begin
			hold_a <= (armed_a_r && state_r == SAPC_ST_IDLE) || state_r == SAPC_ST_CONV;
			hold_b <= (armed_b_r && state_r == SAPC_ST_IDLE) || state_r == SAPC_ST_CONV;
		end
	end

	// ---------------------------------------------------------------
	// Output data registers
	// ---------------------------------------------------------------
	// words stored unchanged as signed codes; cleared on reset.
	genvar g;
	generate
		for (g = 0; g < SAPC_CHANNELS; g++) begin : g_data
			always_ff @(posedge clk or negedge rst_all_n) begin
				if (!rst_all_n) begin
					data_r[g] <= SAPC_DATA_RST;
				end else if (state_r == SAPC_ST_CONV && cnt_r == 16'(CONV_CYC - 1)) begin
					data_r[g] <= conv_data[g*SAPC_RES_BITS +: SAPC_RES_BITS];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Readout
	// ---------------------------------------------------------------
	// Strobe pins pass a local three-stage chain and update only when stages two and three agree.
	logic [2:0] rd_sync_r;
	logic [2:0] cs_sync_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_sync_r <= 3'h7;
			cs_sync_r <= 3'h7;
			rd_q_r <= 1'b1;
			cs_q_r <= 1'b1;
		end else begin
			rd_sync_r <= {rd_sync_r[1:0], rd_sclk};
			cs_sync_r <= {cs_sync_r[1:0], cs_n};
			if (rd_sync_r[1] == rd_sync_r[2]) begin
				rd_q_r <= rd_sync_r[2];
			end
			if (cs_sync_r[1] == cs_sync_r[2]) begin
				cs_q_r <= cs_sync_r[2];
			end
		end
	end
	logic rd_prev_r;
	logic cs_prev_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_prev_r <= 1'b1;
			cs_prev_r <= 1'b1;
		end else begin
			rd_prev_r <= rd_q_r;
			cs_prev_r <= cs_q_r;
		end
	end
	assign rd_fall = rd_prev_r && !rd_q_r;
	assign rd_rise = !rd_prev_r && rd_q_r;
	assign cs_fall = cs_prev_r && !cs_q_r;

	// reading is independent of start levels; serial shifts on clock rise.
	always_ff @(posedge clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			ch_r <= SAPC_CH_RST;
			bit_r <= SAPC_BIT_CNT_RST;
			byte_hi_r <= 1'b1;
		end else if (cs_fall || state_r == SAPC_ST_DONE) begin
			ch_r <= SAPC_CH_RST;
			bit_r <= SAPC_BIT_CNT_RST;
			byte_hi_r <= 1'b1;
		end else if (!cs_q_r) begin
			if (mode_bus.ifsel == SAPC_IF_SER) begin
				if (rd_rise) begin
					if (bit_r == 5'(SAPC_RES_BITS - 1)) begin
						bit_r <= SAPC_BIT_CNT_RST;
						ch_r <= ch_r + 3'h1;
					end else begin
						bit_r <= bit_r + 5'h01;
					end
				end
			end else if (rd_rise) begin
				if (mode_bus.ifsel == SAPC_IF_BYTE && byte_hi_r) begin
					byte_hi_r <= 1'b0;
				end else begin
					byte_hi_r <= 1'b1;
					ch_r <= ch_r + 3'h1;
				end
			end
		end
	end

	// parallel bus enable; serial release on select fall.
	always_ff @(posedge clk or negedge rst_all_n) begin
		if (!rst_all_n) begin
			par_data <= SAPC_DATA_RST;
			par_oe <= 1'b0;
			serial_out_a <= 1'b0;
			serial_out_b <= 1'b0;
			serial_oe <= 1'b0;
		end else begin
			par_oe <= mode_bus.ifsel != SAPC_IF_SER && !cs_q_r && !rd_q_r;
			if (mode_bus.ifsel == SAPC_IF_BYTE) begin
				par_data <= {8'h00, byte_hi_r ? data_r[ch_r][15:8] : data_r[ch_r][7:0]};
			end else begin
				par_data <= data_r[ch_r];
			end
			serial_oe <= mode_bus.ifsel == SAPC_IF_SER && !cs_q_r;
			serial_out_a <= data_r[{1'b0, ch_r[1:0]}][4'(15 - bit_r[3:0])];
			serial_out_b <= data_r[{1'b1, ch_r[1:0]}][4'(15 - bit_r[3:0])];
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_busy_length: assert property (@(posedge clk) disable iff (!rst_all_n)
		$rose(busy) |-> busy [*2]) else $error("busy too short");
	a_busy_needs_both: assert property (@(posedge clk) disable iff (!rst_all_n)
		$rose(busy) |-> $past(armed_a_r) && $past(armed_b_r)) else $error("busy without both starts");
	a_hold_in_conv: assert property (@(posedge clk) disable iff (!rst_all_n)
		busy |-> ##1 (hold_a && hold_b) || !busy) else $error("hold dropped in conversion");
	a_par_enable: assert property (@(posedge clk) disable iff (!rst_all_n)
		par_oe |-> $past(!cs_q_r && !rd_q_r)) else $error("bus driven without strobes");
	a_serial_enable: assert property (@(posedge clk) disable iff (!rst_all_n)
		$fell(cs_q_r) && mode_bus.ifsel == SAPC_IF_SER |-> ##1 serial_oe) else $error("serial not released");
	a_power_mode: assert property (@(posedge clk) disable iff (!rst_n)
		!mode_bus.power_down_n && !mode_bus.span_wide |-> ##1 power_state == SAPC_PWR_OFF) else $error("shutdown missed");
	a_ref_follow: assert property (@(posedge clk) disable iff (!rst_n)
		##1 ref_voltage_pin_oe == $past(mode_bus.ref_internal)) else $error("reference mode wrong");
	a_span_follow: assert property (@(posedge clk) disable iff (!rst_n)
		##1 span_wide == $past(mode_bus.span_wide)) else $error("span not followed");
	a_reset_clear: assert property (@(posedge clk)
		!rst_all_n |-> par_data == 16'h0000 && !busy) else $error("reset did not clear");
	c_conversion: cover property (@(posedge clk) disable iff (!rst_all_n) $fell(busy));
	c_par_read: cover property (@(posedge clk) disable iff (!rst_all_n) par_oe);
	c_ser_read: cover property (@(posedge clk) disable iff (!rst_all_n) serial_oe && rd_rise);
	c_standby: cover property (@(posedge clk) disable iff (!rst_n) power_state == SAPC_PWR_POWER_DOWN_N);
endmodule

// file: shared/sapc_pkg.sv
// Purpose: Shared constants and types for the simultaneous ADC pin control block.
// Assumes: Core clock of 10 MHz; results are 16-bit two's complement words.
// Notes: Analog behaviour is modelled by digital stand-ins only.
package sapc_pkg;
	localparam int SAPC_CLK_HZ = 10000000;
	localparam int SAPC_RES_BITS = 16;
	localparam int SAPC_CHANNELS = 8;
	localparam int SAPC_GROUP = 4;
	// Code step in nanovolts per span: FSR / 65536.
	localparam int SAPC_FSR_STEPS = 65536;
	localparam int SAPC_LSB_WIDE_NV = 305180;
	localparam int SAPC_LSB_NARROW_NV = 152590;
	// Conversion time in nanoseconds and derived clock cycles (longest, rounded down).
	localparam int SAPC_CONV_NS = 2000;
	localparam int SAPC_CONV_CYC = (SAPC_CONV_NS * (SAPC_CLK_HZ / 1000000)) / 1000;
	localparam logic [15:0] SAPC_DATA_RST = 16'h0000;
	localparam logic [4:0] SAPC_BIT_CNT_RST = 5'h00;
	localparam logic [2:0] SAPC_CH_RST = 3'h0;

	typedef enum logic [1:0] {
		SAPC_IF_PAR = 2'b00,
		SAPC_IF_SER = 2'b01,
		SAPC_IF_BYTE = 2'b10
	} sapc_if_t;

	typedef enum logic [1:0] {
		SAPC_PWR_RUN = 2'b00,
		SAPC_PWR_POWER_DOWN_N = 2'b01,
		SAPC_PWR_OFF = 2'b10
	} sapc_pwr_t;

	typedef enum logic [1:0] {
		SAPC_ST_IDLE = 2'b00,
		SAPC_ST_CONV = 2'b01,
		SAPC_ST_DONE = 2'b10
	} sapc_state_t;
endpackage

// file: shared/sapc_mode_if.sv
// Purpose: Carries synchronised mode levels from the synchroniser to the core.
// Assumes: One clock domain.
// Notes: None.
`timescale 1ns/1ps
interface sapc_mode_if;
	logic span_wide;
	logic power_down_n;
	logic ref_internal;
	logic [1:0] ifsel;
	logic start_a;
	logic start_b;
	modport src (output span_wide, power_down_n, ref_internal, ifsel, start_a, start_b);
	modport dst (input span_wide, power_down_n, ref_internal, ifsel, start_a, start_b);
endinterface

// file: logic/sapc_sync.sv
// Purpose: Three-stage synchronisers for the mode and conversion start pins.
// Assumes: A level counts once stages two and three agree.
// Notes: Stage one feeds only stage two.
`timescale 1ns/1ps
module sapc_sync #(
	parameter int N = 7
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Raw pins and held result.
	input wire logic [N-1:0] pin_in,
	output logic [N-1:0] pin_out
);
	logic [N-1:0] s1_r;
	logic [N-1:0] s2_r;
	logic [N-1:0] s3_r;
	logic [N-1:0] hold_r;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_r[i] <= 1'b0;
					s2_r[i] <= 1'b0;
					s3_r[i] <= 1'b0;
					hold_r[i] <= 1'b0;
				end else begin
					s1_r[i] <= pin_in[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (s2_r[i] == s3_r[i]) begin
						hold_r[i] <= s3_r[i];
					end
				end
			end
		end
	endgenerate

	assign pin_out = hold_r;
endmodule

// file: verification/sapc_host_model.sv
// Purpose: Host model that frames reads on chip select and the dual-role pin.
// Assumes: Pins step on the falling clock edge and hold eight cycles a phase.
// Notes: The slow pace leaves room for the pin synchronisers in the block.
`timescale 1ns/1ps
module sapc_host_model (
	// Clock.
	input wire logic clk,
	// Read pins.
	output logic cs_n,
	output logic rd_sclk,
	// Returned data.
	input wire logic [15:0] par_data,
	input wire logic par_oe,
	input wire logic serial_out_a,
	input wire logic serial_out_b,
	input wire logic serial_oe
);
	logic [15:0] got[8];
	logic oe_seen;

	initial begin
		cs_n = 1'b1;
		rd_sclk = 1'b1;
		oe_seen = 1'b0;
	end

	task automatic settle();
		repeat (8) @(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// Read framing
	// ----------------------------------------------------------------
	// serial clock rising
	task automatic read_frame(input logic [1:0] mode);
		oe_seen = 1'b1;
		if (mode == 2'b01) begin
			// The clock sits low before the frame so the first rise is a real edge.
			rd_sclk = 1'b0;
			settle();
			cs_n = 1'b0;
			settle();
			for (int i = 0; i < 64; i++) begin
				oe_seen = oe_seen & serial_oe;
				got[i / 16][15 - (i % 16)] = serial_out_a;
				got[4 + i / 16][15 - (i % 16)] = serial_out_b;
				rd_sclk = 1'b1;
				settle();
				rd_sclk = 1'b0;
				settle();
			end
		end else begin
			cs_n = 1'b0;
			settle();
			for (int i = 0; i < ((mode == 2'b10) ? 16 : 8); i++) begin
				rd_sclk = 1'b0;
				settle();
				oe_seen = oe_seen & par_oe;
				if (mode == 2'b00) begin
					got[i] = par_data;
				end else if (i % 2 == 0) begin
					got[i / 2][15:8] = par_data[7:0];
				end else begin
					got[i / 2][7:0] = par_data[7:0];
				end
				rd_sclk = 1'b1;
				settle();
			end
		end
		cs_n = 1'b1;
		rd_sclk = 1'b1;
		settle();
	endtask
endmodule

// file: verification/testbench.sv
// Purpose: Self-checking bench for the converter pin control block.
// Assumes: Conversion length shortened to four cycles.
// Notes: Expected words come from a model filled with seeded random values.
`timescale 1ns/1ps
module testbench;
	import sapc_pkg::*;
	localparam int CONV = 4;
	logic clk, rst_n, reset_pin, ref_sel, range_sel, pd_n, if_sel, byte_sel;
	logic st_a, st_b, cs_n, rd_sclk, ref_int, ref_oe, ref_buf, span_wide;
	logic hold_a, hold_b, busy, par_oe, sout_a, sout_b, ser_oe;
	logic [127:0] conv_data;
	logic [1:0] pwr;
	logic [15:0] par_data;
	int failures, checks_done, seed, k;
	int exp_w[8];

	sapc_core #(.CONV_CYC(CONV)) i_dut (
		.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin), .ref_source_select(ref_sel),
		.range_select(range_sel), .power_down_n(pd_n), .interface_select(if_sel),
		.msb_or_byte_select(byte_sel), .sample_start_a(st_a), .sample_start_b(st_b),
		.cs_n(cs_n), .rd_sclk(rd_sclk), .conv_data(conv_data), .ref_internal_en(ref_int),
		.ref_voltage_pin_oe(ref_oe), .ref_buffer_en(ref_buf), .span_wide(span_wide),
		.power_state(pwr), .hold_a(hold_a), .hold_b(hold_b), .busy(busy),
		.par_data(par_data), .par_oe(par_oe), .serial_out_a(sout_a),
		.serial_out_b(sout_b), .serial_oe(ser_oe));

	sapc_host_model i_host (
		.clk(clk), .cs_n(cs_n), .rd_sclk(rd_sclk), .par_data(par_data), .par_oe(par_oe),
		.serial_out_a(sout_a), .serial_out_b(sout_b), .serial_oe(ser_oe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Compare and control tasks
	// ----------------------------------------------------------------
	task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_flag(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wait_busy();
		k = 0;
		while (busy !== 1'b1 && k < 20) begin
			cyc(1);
			k++;
		end
	endtask

	// Start A first, then B; the starts stay high through the following read.
	task automatic convert();
		for (int i = 0; i < 8; i++) begin
			exp_w[i] = $random(seed) & 32'h0000ffff;
			conv_data[16 * i +: 16] = exp_w[i][15:0];
		end
		st_a = 1'b1;
		cyc(6);
		check_flag(busy, 1'b0);
		st_b = 1'b1;
		wait_busy();
		check_flag(busy, 1'b1);
		check_flag(hold_a & hold_b, 1'b1);
		k = 0;
		while (busy === 1'b1 && k < 100) begin
			k++;
			cyc(1);
		end
		check_word(k[15:0], 16'(CONV));
	endtask

	task automatic read_check(input logic [1:0] mode, input logic zero);
		if_sel = (mode != 2'b00);
		byte_sel = (mode == 2'b10) | ((mode == 2'b00) & seed[0]);
		cyc(8);
		i_host.read_frame(mode);
		check_flag(i_host.oe_seen, 1'b1);
		for (int i = 0; i < 8; i++) begin
			check_word(i_host.got[i], zero ? 16'h0000 : exp_w[i][15:0]);
		end
		check_flag(par_oe | ser_oe, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 32'h7d71;
		failures = 0;
		checks_done = 0;
		{rst_n, reset_pin, pd_n, if_sel, byte_sel, st_a, st_b} = 7'h34;
		ref_sel = 1'b1;
		range_sel = 1'b1;
		conv_data = {8{16'h0000}};
		cyc(16);
		rst_n = 1'b1;
		reset_pin = 1'b0;
		cyc(8);
		for (int i = 0; i < 4; i++) begin
			ref_sel = i[0];
			range_sel = i[1];
			cyc(8);
			check_flag(ref_int, i[0]);
			check_flag(ref_oe, i[0]);
			check_flag(ref_buf, 1'b1);
			check_flag(span_wide, i[1]);
			pd_n = 1'b0;
			cyc(8);
			check_word({14'h0000, pwr}, i[1] ? 16'h0001 : 16'h0002);
			check_flag(ref_buf, i[1]);
			check_flag(ref_int, i[0] & i[1]);
			pd_n = 1'b1;
			cyc(8);
			check_word({14'h0000, pwr}, 16'h0000);
		end
		cyc(1000);
		for (int m = 0; m < 3; m++) begin
			convert();
			read_check(m[1:0], 1'b0);
			st_a = 1'b0;
			st_b = 1'b0;
			cyc(4);
		end
		st_a = 1'b1;
		st_b = 1'b1;
		wait_busy();
		reset_pin = 1'b1;
		cyc(2);
		check_flag(busy, 1'b0);
		cyc(4);
		reset_pin = 1'b0;
		st_a = 1'b0;
		st_b = 1'b0;
		cyc(20);
		read_check(2'b00, 1'b1);
		print_verdict();
	end

	initial begin
		#3000000;
		failures++;
		print_verdict();
	end
endmodule
